// file: src/xebc_top.sv
// Extended block command register, slot walk and fetch request buffer
//
// How it works
// [RQ1] The command register loads only from the extended word of a 32-source descriptor and ignores software writes.
// [RQ2] Each new extended descriptor replaces the register, which steers only that descriptor's walk.
// [RQ3] The register holds one operation field for each of source slots seventeen to twenty-one.
// [RQ4] Bits 26:25 of the main control word tell whether an extended section follows.
// [RQ5] Slot twenty-one's code sits in bits 15:13 and resets to zero.
// [RQ6] Slot twenty's code sits in bits 12:10 and resets to zero.
// [RQ7] Slot nineteen's code sits in bits 9:7 and resets to zero.
// [RQ8] Slot eighteen's code sits in bits 6:4 and resets to zero.
// [RQ9] Slot seventeen's code sits in bits 3:1, bit 0 is reserved, all reset to zero.
// [RQ10] A null code skips its slot and issues no fetch for it.
// [RQ11] An XOR code issues a fetch of that slot's data into the XOR unit.
// [RQ12] The descriptor producer uses only the null and XOR codes.
// [RQ13] Without an extended section the walk over slots seventeen and up is skipped.
`timescale 1ns/1ps
`default_nettype none
`include "xebc_cfg.svh"

module xebc_top (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // Main descriptor control word from the fetch engine
    input wire logic DESC_VALID,
    input wire logic [31:0] DESC_CTRL,
    output logic DESC_READY,
    // Extended section word from the fetch engine
    input wire logic EXT_VALID,
    input wire logic [31:0] EXT_WORD,
    output logic EXT_READY,
    // Internal bus read port
    input wire logic RD_EN,
    input wire logic [31:0] RD_ADDR,
    output logic [31:0] RD_DATA,
    output logic RD_ACK,
    // Internal bus write port, answered but never stored
    input wire logic WR_EN,
    input wire logic [31:0] WR_ADDR,
    input wire logic [31:0] WR_DATA,
    output logic WR_ACK,
    // Source fetch requests toward the XOR unit
    output logic FETCH_VALID,
    output logic [4:0] FETCH_SLOT,
    input wire logic FETCH_READY,
    // End of one descriptor, after its extended walk or with the walk skipped
    output logic WALK_DONE
);

    // Code of walk position idx (0 is slot seventeen)
    function automatic logic [2:0] code_of(input logic [31:0] word,
                                           input logic [2:0] idx);
        logic [5:0] lsb;
        lsb = 6'(`XEBC_B17_LSB) + 6'(idx) * 6'(`XEBC_FIELD_W); // [RQ3]
        code_of = 3'(word >> lsb);
    endfunction : code_of

    xebc_pkg::xebc_state_type state_reg, state_next;
    logic [31:0] cmd_reg, cmd_next;
    logic [2:0] idx_reg, idx_next;
    logic done_reg, done_next;
    logic desc_rdy_reg, desc_rdy_next;
    logic ext_rdy_reg, ext_rdy_next;
    logic head_v_reg, head_v_next, tail_v_reg, tail_v_next;
    logic [4:0] head_s_reg, head_s_next, tail_s_reg, tail_s_next;
    logic [31:0] rd_data_reg, rd_data_next;
    logic rd_ack_reg, rd_ack_next, wr_ack_reg, wr_ack_next;
    logic desc_take, ext_take, ext_sel, push, pop;
    logic [2:0] cur_code;
    logic [4:0] push_slot;

    assign desc_take = DESC_VALID && state_reg == xebc_pkg::ST_IDLE;
    assign ext_take = EXT_VALID && state_reg == xebc_pkg::ST_WAIT_EXT;
    // Any other value of the selector means fewer than 32 sources
    assign ext_sel = DESC_CTRL[`XEBC_EXT_MSB:`XEBC_EXT_LSB]
                     == `XEBC_EXT_32SRC; // [RQ4]
    assign cur_code = code_of(cmd_reg, idx_reg);
    // Reserved codes are treated as null so a bad producer fetches nothing
    assign push = state_reg == xebc_pkg::ST_WALK && !tail_v_reg
                  && cur_code == `XEBC_CODE_XOR; // [RQ11] [RQ12]
    assign push_slot = `XEBC_FIRST_SLOT + 5'(idx_reg);
    assign pop = head_v_reg && FETCH_READY;

    // Descriptor control and slot walk
    always_comb begin
        state_next = state_reg;
        cmd_next = cmd_reg;
        idx_next = idx_reg;
        done_next = 1'b0;
        case (state_reg)
            xebc_pkg::ST_IDLE: begin
                if (desc_take) begin
                    idx_next = 3'h0;
                    if (ext_sel) begin
                        state_next = xebc_pkg::ST_WAIT_EXT; // [RQ4]
                    end else begin
                        state_next = xebc_pkg::ST_DONE; // [RQ13]
                    end
                end
            end
            xebc_pkg::ST_WAIT_EXT: begin
                if (ext_take) begin
                    // Only path that changes the register [RQ1] [RQ2]
                    cmd_next = EXT_WORD & `XEBC_CMD_MASK; // [RQ9]
                    state_next = xebc_pkg::ST_WALK;
                end
            end
            xebc_pkg::ST_WALK: begin
                // A null slot advances at once; XOR waits for buffer room
                if (push || cur_code != `XEBC_CODE_XOR) begin // [RQ10]
                    if (idx_reg == `XEBC_LAST_IDX) begin
                        state_next = xebc_pkg::ST_DONE;
                    end else begin
                        idx_next = idx_reg + 3'h1;
                    end
                end
            end
            xebc_pkg::ST_DONE: begin
                done_next = 1'b1;
                state_next = xebc_pkg::ST_IDLE;
            end
            default: begin
                state_next = xebc_pkg::ST_IDLE;
            end
        endcase
        desc_rdy_next = state_next == xebc_pkg::ST_IDLE;
        ext_rdy_next = state_next == xebc_pkg::ST_WAIT_EXT;
    end

    // Control registers; fields reset to zero [RQ5] [RQ6] [RQ7] [RQ8]
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_reg <= xebc_pkg::ST_IDLE;
            cmd_reg <= `XEBC_CMD_RESET; // [RQ9]
            idx_reg <= 3'h0;
            done_reg <= 1'b0;
            desc_rdy_reg <= 1'b1;
            ext_rdy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cmd_reg <= cmd_next;
            idx_reg <= idx_next;
            done_reg <= done_next;
            desc_rdy_reg <= desc_rdy_next;
            ext_rdy_reg <= ext_rdy_next;
        end
    end

    // Two-entry fetch buffer; head feeds the outputs directly
    always_comb begin
        head_v_next = head_v_reg;
        head_s_next = head_s_reg;
        tail_v_next = tail_v_reg;
        tail_s_next = tail_s_reg;
        if (pop) begin
            if (tail_v_reg) begin
                head_s_next = tail_s_reg;
                tail_v_next = 1'b0;
            end else begin
                head_v_next = push;
                head_s_next = push_slot;
            end
        end else if (push) begin
            if (!head_v_reg) begin
                head_v_next = 1'b1;
                head_s_next = push_slot;
            end else begin
                tail_v_next = 1'b1;
                tail_s_next = push_slot;
            end
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            head_v_reg <= 1'b0;
            head_s_reg <= 5'h00;
            tail_v_reg <= 1'b0;
            tail_s_reg <= 5'h00;
        end else begin
            head_v_reg <= head_v_next;
            head_s_reg <= head_s_next;
            tail_v_reg <= tail_v_next;
            tail_s_reg <= tail_s_next;
        end
    end

    // Bus answers; a write is acknowledged and dropped
    always_comb begin
        rd_ack_next = RD_EN;
        rd_data_next = 32'h00000000;
        if (RD_EN && RD_ADDR == `XEBC_CMD_ADDR) begin
            rd_data_next = cmd_reg; // [RQ3]
        end
        wr_ack_next = WR_EN; // [RQ1]
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rd_ack_reg <= 1'b0;
            rd_data_reg <= 32'h00000000;
            wr_ack_reg <= 1'b0;
        end else begin
            rd_ack_reg <= rd_ack_next;
            rd_data_reg <= rd_data_next;
            wr_ack_reg <= wr_ack_next;
        end
    end

    assign DESC_READY = desc_rdy_reg;
    assign EXT_READY = ext_rdy_reg;
    assign RD_DATA = rd_data_reg;
    assign RD_ACK = rd_ack_reg;
    assign WR_ACK = wr_ack_reg;
    assign FETCH_VALID = head_v_reg;
    assign FETCH_SLOT = head_s_reg;
    assign WALK_DONE = done_reg;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    sequence s_plain_desc;
        desc_take && !ext_sel;
    endsequence

    sequence s_skip_finish;
        state_reg == xebc_pkg::ST_DONE && !push ##1 WALK_DONE;
    endsequence

    a_no_sw_write: assert property ( // [RQ1]
        WR_EN && !ext_take |=> cmd_reg == $past(cmd_reg)
    ) else $error("command register changed by a write");

    a_ext_load_word: assert property ( // [RQ2]
        ext_take |=> cmd_reg == ($past(EXT_WORD) & 32'h0000fffe)
    ) else $error("extended word not loaded");

    a_load_only_ext: assert property ( // [RQ1]
        !ext_take |=> $stable(cmd_reg)
    ) else $error("command register loaded without extended word");

    a_rsvd_bits_zero: assert property ( // [RQ9]
        cmd_reg[0] == 1'b0 && cmd_reg[31:16] == 16'h0000
    ) else $error("reserved bits not zero");

    a_ext_detect_sel: assert property ( // [RQ4]
        desc_take && ext_sel |=> state_reg == xebc_pkg::ST_WAIT_EXT
    ) else $error("extended section not awaited");

    a_plain_skip_walk: assert property ( // [RQ13]
        s_plain_desc |=> s_skip_finish
    ) else $error("walk run without extended section");

    a_null_no_fetch: assert property ( // [RQ10]
        push |-> cmd_reg[5'(`XEBC_B17_LSB) + 5'(3) * 5'(idx_reg) +: 3] == 3'h1
    ) else $error("fetch issued for a non-XOR slot");

    a_xor_fetch_slot: assert property ( // [RQ11]
        push && !head_v_reg |=> FETCH_VALID && FETCH_SLOT == $past(push_slot)
    ) else $error("XOR slot not presented for fetch");

    a_read_value: assert property ( // [RQ3]
        RD_EN && RD_ADDR == 32'hffffe860 |=> RD_ACK && RD_DATA == $past(cmd_reg)
    ) else $error("register read returned wrong value");

    a_stall_hold: assert property (
        FETCH_VALID && !FETCH_READY |=> FETCH_VALID && $stable(FETCH_SLOT)
    ) else $error("fetch request dropped under stall");

    // A busy memory may hold the walk as long as it likes, so no fixed
    // bound fits; with room in the buffer, each cycle must advance it
    a_walk_bound: assert property ( // [RQ2]
        state_reg == xebc_pkg::ST_WALK && !tail_v_reg
        |=> state_reg == xebc_pkg::ST_DONE
            || idx_reg == $past(idx_reg) + 3'h1
    ) else $error("walk did not advance");

endmodule : xebc_top

`default_nettype wire

// file: src/xebc_cfg.svh
// Offsets, field positions, reset values and codes of the extended command block
`ifndef XEBC_CFG_SVH
`define XEBC_CFG_SVH

// Register address on the internal bus
`define XEBC_CMD_ADDR 32'hffffe860
`define XEBC_CMD_RESET 32'h00000000
// Bits that hold fields; bit 0 and bits above 15 read as zero
`define XEBC_CMD_MASK 32'h0000fffe

// Field positions, three bits each
`define XEBC_FIELD_W 3
`define XEBC_B17_LSB 1
`define XEBC_B18_LSB 4
`define XEBC_B19_LSB 7
`define XEBC_B20_LSB 10
`define XEBC_B21_LSB 13

// Per-block operation codes; all others are reserved
`define XEBC_CODE_NULL 3'h0
`define XEBC_CODE_XOR 3'h1

// Extended section selector in the main descriptor control word
`define XEBC_EXT_LSB 25
`define XEBC_EXT_MSB 26
`define XEBC_EXT_32SRC 2'h3

// Slot walk
`define XEBC_FIRST_SLOT 5'h11
`define XEBC_LAST_IDX 3'h4

`endif

// file: src/xebc_pkg.sv
// Types shared by the extended block command logic
`default_nettype none
package xebc_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_EXT,
        ST_WALK,
        ST_DONE
    } xebc_state_type;

endpackage : xebc_pkg

`default_nettype wire

// file: testbench/xebc_mem_model.sv
// Memory model: offers descriptor words and takes fetch requests
`timescale 1ns/1ps
`default_nettype none
module xebc_mem_model (
    // Clock
    input wire logic clk,
    // Descriptor words
    output logic desc_valid,
    output logic [31:0] desc_ctrl,
    input wire logic desc_ready,
    output logic ext_valid,
    output logic [31:0] ext_word,
    input wire logic ext_ready,
    // Fetch requests
    input wire logic fetch_valid,
    input wire logic [4:0] fetch_slot,
    output logic fetch_ready,
    // Stall from the bench
    input wire logic stall
);
    logic [4:0] got[$];
    // A stalled memory refuses requests
    assign fetch_ready = !stall;
    initial begin
        desc_valid = 1'b0;
        desc_ctrl = 32'h0;
        ext_valid = 1'b0;
        ext_word = 32'h0;
    end
    // Log every slot the memory serves
    always @(posedge clk) begin
        if (fetch_valid && fetch_ready) begin
            got.push_back(fetch_slot);
        end
    end
    // One descriptor, then its extended word if the selector asks
    task automatic send(input logic [31:0] ctrl, input logic [31:0] word);
        @(posedge clk);
        #1;
        desc_valid = 1'b1;
        desc_ctrl = ctrl;
        do @(posedge clk); while (desc_ready !== 1'b1);
        #1;
        desc_valid = 1'b0;
        desc_ctrl = ~ctrl; // Released lines show no stale word
        if (ctrl[26:25] == 2'h3) begin
            ext_valid = 1'b1;
            ext_word = word;
            do @(posedge clk); while (ext_ready !== 1'b1);
            #1;
            ext_valid = 1'b0;
            ext_word = ~word;
        end
    endtask : send
endmodule : xebc_mem_model
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for the extended block command logic
`timescale 1ns/1ps
`default_nettype none
`include "xebc_cfg.svh"
module tb;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic desc_valid, desc_ready, ext_valid, ext_ready, stall;
    logic [31:0] desc_ctrl, ext_word, rd_addr, rd_data, wr_addr, wr_data;
    logic rd_en, rd_ack, wr_en, wr_ack, fetch_valid, fetch_ready, walk_done;
    logic [4:0] fetch_slot;
    logic [31:0] reg_exp;
    int fails = 0;
    int cmp_count = 0;
    int cyc = 0;
    int dones = 0;

    xebc_top uut (.CLK(clk), .RESET_N(reset_n), .DESC_VALID(desc_valid),
        .DESC_CTRL(desc_ctrl), .DESC_READY(desc_ready),
        .EXT_VALID(ext_valid), .EXT_WORD(ext_word), .EXT_READY(ext_ready),
        .RD_EN(rd_en), .RD_ADDR(rd_addr), .RD_DATA(rd_data), .RD_ACK(rd_ack),
        .WR_EN(wr_en), .WR_ADDR(wr_addr), .WR_DATA(wr_data), .WR_ACK(wr_ack),
        .FETCH_VALID(fetch_valid), .FETCH_SLOT(fetch_slot),
        .FETCH_READY(fetch_ready), .WALK_DONE(walk_done));
    xebc_mem_model mem (.clk(clk), .desc_valid(desc_valid),
        .desc_ctrl(desc_ctrl), .desc_ready(desc_ready),
        .ext_valid(ext_valid), .ext_word(ext_word), .ext_ready(ext_ready),
        .fetch_valid(fetch_valid), .fetch_slot(fetch_slot),
        .fetch_ready(fetch_ready), .stall(stall));

    // Clock, hang limit well above the few hundred cycles needed
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (walk_done === 1'b1) dones++;
        if (cyc == 4000) begin
            fails++;
            summarize();
        end
    end

    task automatic summarize();
        if (fails == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One-cycle strobes; the answer stands in the following cycle
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        rd_en = 1'b1;
        rd_addr = a;
        @(posedge clk);
        #1;
        rd_en = 1'b0;
        rd_addr = ~a;
        chk({31'h0, rd_ack}, 32'h1);
        chk(rd_data, exp);
        @(posedge clk);
        #1;
    endtask : rd
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        wr_en = 1'b1;
        wr_addr = a;
        wr_data = d;
        @(posedge clk);
        #1;
        wr_en = 1'b0;
        chk({31'h0, wr_ack}, 32'h1);
        @(posedge clk);
        #1;
    endtask : wr

    // Stalled memory fills the buffer, then slots must come in order
    task automatic run(input logic [31:0] ctrl, input logic [31:0] word);
        logic [4:0] exp[$];
        int n;
        int d0;
        n = 0;
        d0 = dones;
        mem.got.delete();
        if (ctrl[26:25] == 2'h3) begin
            reg_exp = word & `XEBC_CMD_MASK;
            for (int i = 0; i < 5; i++) begin
                if (word[1 + 3 * i +: 3] == `XEBC_CODE_XOR) begin
                    exp.push_back(`XEBC_FIRST_SLOT + 5'(i));
                end
            end
        end
        stall = 1'b1;
        fork
            mem.send(ctrl, word);
        join_none
        repeat (14) @(posedge clk);
        #1;
        stall = 1'b0;
        while (n < 60 && (dones == d0 || fetch_valid !== 1'b0)) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(32'(dones - d0), 32'h1);
        chk(32'(mem.got.size()), 32'(exp.size()));
        foreach (exp[k]) begin
            if (k < mem.got.size()) chk({27'h0, mem.got[k]}, {27'h0, exp[k]});
        end
    endtask : run

    // Main sequence
    initial begin
        rd_en = 1'b0;
        rd_addr = 32'h0;
        wr_en = 1'b0;
        wr_addr = 32'h0;
        wr_data = 32'h0;
        stall = 1'b0;
        reg_exp = `XEBC_CMD_RESET;
        repeat (4) @(posedge clk);
        #1;
        reset_n = 1'b1;
        rd(`XEBC_CMD_ADDR, 32'h0);
        wr(`XEBC_CMD_ADDR, 32'hffffffff);
        rd(`XEBC_CMD_ADDR, 32'h0);
        rd(32'hffffe864, 32'h0);
        run(32'h06000000, 32'hffff2493);
        rd(`XEBC_CMD_ADDR, reg_exp);
        for (int i = 0; i < 5; i++) begin
            run(32'h06000000, 32'h2 << (3 * i));
            rd(`XEBC_CMD_ADDR, reg_exp);
        end
        // Null and XOR mixed in one descriptor; the producer never uses
        // a reserved code
        run(32'h06000000, 32'h00002010);
        rd(`XEBC_CMD_ADDR, reg_exp);
        for (int s = 0; s < 3; s++) begin
            run({5'h0, 2'(s), 25'h0}, 32'h00002492);
        end
        rd(`XEBC_CMD_ADDR, reg_exp);
        summarize();
    end
endmodule : tb
`default_nettype wire
